// ---- atseq_sequencer.sv ----
/*
 Acquisition trigger sequencer: start and reference triggers, sample tick
 generation from a timebase divider, sample counter, stop modes, and a
 sample FIFO. Assumes pins and trigger sources are asynchronous and the
 host drives configuration ports steady while running.
*/
module atseq_sequencer #(
   parameter int SAMPLE_W = 16,
   parameter int FIFO_DEPTH = 16
) (
   // Clock and reset
   input  wire logic                                clk,
   input  wire logic                                reset,
   // Host configuration
   input  wire atseq_pkg::atseq_src_t               start_src,
   input  wire atseq_pkg::atseq_src_t               ref_src,
   input  wire atseq_pkg::atseq_stop_t              stop_mode,
   input  wire logic [atseq_pkg::SEL_W-1:0]         start_sel,
   input  wire logic [atseq_pkg::SEL_W-1:0]         ref_sel,
   input  wire logic                                start_falling,
   input  wire logic                                ref_falling,
   input  wire logic                                tick_falling,
   input  wire logic [atseq_pkg::COUNT_W-1:0]       buffer_size,
   input  wire logic [atseq_pkg::COUNT_W-1:0]       pretrigger_count,
   input  wire logic [atseq_pkg::DIV_W-1:0]         tick_divisor,
   input  wire logic [atseq_pkg::DELAY_W-1:0]       first_tick_delay,
   input  wire logic                                start_pin_output,
   // Host commands
   input  wire logic                                sw_start,
   input  wire logic                                sw_stop,
   // Trigger sources (asynchronous)
   input  wire logic [atseq_pkg::PIN_N-1:0]         programmable_function_pin,
   input  wire logic [atseq_pkg::BUS_N-1:0]         system_timing_bus_line,
   input  wire logic [atseq_pkg::INT_N-1:0]         internal_source,
   input  wire logic                                analog_compare_event,
   input  wire logic                                sample_tick_timebase,
   // Start trigger pin
   input  wire logic                                start_trigger_pin_in,
   output logic                                     start_trigger_output_pin,
   output logic                                     start_trigger_pin_oe,
   // Sample data
   input  wire logic [SAMPLE_W-1:0]                 sample_data,
   output logic                                     sample_valid,
   input  wire logic                                sample_ready,
   output logic [SAMPLE_W-1:0]                      sample_out,
   // Status
   output logic                                     acq_running,
   output logic                                     acq_complete,
   output logic                                     acq_overflow,
   output logic                                     sample_tick,
   output logic [atseq_pkg::COUNT_W-1:0]            sample_count
);
   localparam int SRC_N = atseq_pkg::PIN_N + atseq_pkg::BUS_N + atseq_pkg::INT_N + 1;
   localparam logic [1:0] SETTLE_DONE = 2'h3;
   initial
   begin
      if (SRC_N > (1 << atseq_pkg::SEL_W)) $error("Selector too narrow");
      if (SAMPLE_W < 1) $error("SAMPLE_W must be positive");
   end

   // ********************
   // State
   // ********************
   typedef struct packed {
      logic [SRC_N-1:0]               sync1;
      logic [SRC_N-1:0]               sync2;
      logic                           tb1;
      logic                           tb2;
      logic                           tb_prev;
      logic                           start_prev;
      logic                           ref_prev;
      logic                           ana_prev;
      logic [1:0]                     settle;
      atseq_pkg::atseq_state_t        state;
      logic [atseq_pkg::COUNT_W-1:0]  count;
      logic [atseq_pkg::DIV_W-1:0]    div;
      logic [atseq_pkg::DELAY_W-1:0]  delay;
      logic                           start_pulse;
      logic                           oe;
      logic                           running;
      logic                           complete;
      logic                           overflow;
      logic                           tick;
   } atseq_state_reg_t;

   atseq_state_reg_t st;
   atseq_state_reg_t next_st;
   logic             fifo_in_ready;
   logic             fifo_out_valid;
   logic [SAMPLE_W-1:0] fifo_out_data;

   // Source list: function pins (pin 0 is the start pin), bus lines, internals
   function automatic logic pick(input logic [SRC_N-1:0] srcs,
                                 input logic [atseq_pkg::SEL_W-1:0] sel);
      pick = (int'(sel) < SRC_N) ? srcs[sel] : 1'b0;
   endfunction

   function automatic logic edge_seen(input logic now, input logic prev,
                                      input logic falling);
      edge_seen = falling ? (prev && !now) : (!prev && now);
   endfunction

   // ********************
   // Next state
   // ********************
   always_comb
   begin
      logic start_lvl;
      logic ref_lvl;
      logic tb_edge;
      logic start_go;
      logic ref_go;
      logic tick_now;
      logic edges_ok;
      logic [atseq_pkg::COUNT_W-1:0] post_count;
      start_lvl  = 1'b0;
      ref_lvl    = 1'b0;
      tb_edge    = 1'b0;
      start_go   = 1'b0;
      ref_go     = 1'b0;
      tick_now   = 1'b0;
      edges_ok   = 1'b0;
      post_count = buffer_size - pretrigger_count;
      next_st    = st;

      next_st.sync1 = {analog_compare_event, internal_source, system_timing_bus_line,
                       programmable_function_pin[atseq_pkg::PIN_N-1:1],
                       st.oe ? 1'b0 : start_trigger_pin_in};
      next_st.sync2 = st.sync1;
      // No trigger edges until synchronisers and prev flops hold real levels
      next_st.settle = (st.settle == SETTLE_DONE) ? st.settle : st.settle + 2'h1;
      edges_ok       = st.settle == SETTLE_DONE;
      next_st.tb1   = sample_tick_timebase;
      next_st.tb2   = st.tb1;
      next_st.tb_prev = st.tb2;
      tb_edge = edge_seen(st.tb2, st.tb_prev, tick_falling);

      // ********************
      // Trigger detection
      // ********************
      start_lvl = pick(st.sync2, start_sel);
      ref_lvl   = pick(st.sync2, ref_sel);
      next_st.start_prev = start_lvl;
      next_st.ref_prev   = ref_lvl;
      next_st.ana_prev   = st.sync2[SRC_N-1];

      case (start_src)
         atseq_pkg::ATSEQ_SRC_DIGITAL:
            start_go = edges_ok && edge_seen(start_lvl, st.start_prev, start_falling);
         atseq_pkg::ATSEQ_SRC_ANALOG:
            start_go = edges_ok && st.sync2[SRC_N-1] && !st.ana_prev;
         default:
            start_go = sw_start;
      endcase
      case (ref_src)
         atseq_pkg::ATSEQ_SRC_DIGITAL:
            ref_go = edges_ok && edge_seen(ref_lvl, st.ref_prev, ref_falling);
         atseq_pkg::ATSEQ_SRC_ANALOG:
            ref_go = edges_ok && st.sync2[SRC_N-1] && !st.ana_prev;
         default:
            ref_go = 1'b0;
      endcase

      next_st.start_pulse = 1'b0;
      next_st.tick        = 1'b0;
      next_st.oe          = start_pin_output;

      // ********************
      // Sample tick divider
      // ********************
      if (st.state != atseq_pkg::ATSEQ_IDLE && tb_edge)
      begin
         if (st.state == atseq_pkg::ATSEQ_DELAY)
            next_st.delay = st.delay - 1'b1;
         else if (st.div <= 16'h0001)
         begin
            next_st.div = tick_divisor;
            tick_now = 1'b1;
         end
         else
            next_st.div = st.div - 1'b1;
      end
      next_st.tick = tick_now;

      case (st.state)
         atseq_pkg::ATSEQ_IDLE:
            if (start_go)
            begin
               // Pulse only when the pin drives in the same cycle
               next_st.start_pulse = start_pin_output;
               next_st.running  = 1'b1;
               next_st.complete = 1'b0;
               next_st.delay    = (first_tick_delay == '0) ? 8'h01 : first_tick_delay;
               next_st.div      = tick_divisor;
               next_st.state    = atseq_pkg::ATSEQ_DELAY;
               if (stop_mode == atseq_pkg::ATSEQ_STOP_REF)
                  next_st.count = pretrigger_count;
               else
                  next_st.count = post_count;
            end
         atseq_pkg::ATSEQ_DELAY:
            if (tb_edge && st.delay <= 8'h01)
            begin
               next_st.tick = 1'b1;
               tick_now     = 1'b1;
               case (stop_mode)
                  atseq_pkg::ATSEQ_STOP_REF:  next_st.state = atseq_pkg::ATSEQ_PRE;
                  atseq_pkg::ATSEQ_STOP_CONT: next_st.state = atseq_pkg::ATSEQ_RUN;
                  default:                    next_st.state = atseq_pkg::ATSEQ_POST;
               endcase
               if (stop_mode != atseq_pkg::ATSEQ_STOP_CONT && st.count != atseq_pkg::COUNT_ZERO)
                  next_st.count = st.count - atseq_pkg::COUNT_ONE;
               if (stop_mode == atseq_pkg::ATSEQ_STOP_REF && st.count <= atseq_pkg::COUNT_ONE)
               begin
                  next_st.count = post_count;
                  next_st.state = atseq_pkg::ATSEQ_ARMED;
               end
               else if (stop_mode == atseq_pkg::ATSEQ_STOP_COUNT
                        && st.count <= atseq_pkg::COUNT_ONE)
               begin
                  next_st.state    = atseq_pkg::ATSEQ_IDLE;
                  next_st.running  = 1'b0;
                  next_st.complete = 1'b1;
               end
            end
         atseq_pkg::ATSEQ_PRE:
            if (tick_now)
            begin
               next_st.count = st.count - atseq_pkg::COUNT_ONE;
               if (st.count <= atseq_pkg::COUNT_ONE)
               begin
                  next_st.count = post_count;
                  next_st.state = atseq_pkg::ATSEQ_ARMED;
               end
            end
         atseq_pkg::ATSEQ_ARMED:
            if (ref_go)
               next_st.state = atseq_pkg::ATSEQ_POST;
         atseq_pkg::ATSEQ_POST:
            if (tick_now)
            begin
               next_st.count = st.count - atseq_pkg::COUNT_ONE;
               if (st.count <= atseq_pkg::COUNT_ONE)
               begin
                  next_st.count    = atseq_pkg::COUNT_ZERO;
                  next_st.state    = atseq_pkg::ATSEQ_IDLE;
                  next_st.running  = 1'b0;
                  next_st.complete = 1'b1;
               end
            end
         atseq_pkg::ATSEQ_RUN: ;
         default:
            next_st.state = atseq_pkg::ATSEQ_IDLE;
      endcase
      // Software stop overrides any transition out of a non-idle state; a start from idle still goes ahead
      if (sw_stop && st.state != atseq_pkg::ATSEQ_IDLE)
      begin
         next_st.state   = atseq_pkg::ATSEQ_IDLE;
         next_st.running = 1'b0;
      end
      if (tick_now && !fifo_in_ready)
         next_st.overflow = 1'b1;
      else if (start_go && st.state == atseq_pkg::ATSEQ_IDLE)
         next_st.overflow = 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         st       <= '0;
         st.state <= atseq_pkg::ATSEQ_IDLE;
         st.oe    <= 1'b0;
      end
      else
         st <= next_st;
   end

   // ********************
   // Sample buffer
   // ********************
   atseq_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .reset     (reset),
      .in_valid  (st.tick),
      .in_ready  (fifo_in_ready),
      .in_data   (sample_data),
      .out_valid (fifo_out_valid),
      .out_ready (sample_ready),
      .out_data  (fifo_out_data)
   );

   // ********************
   // Outputs
   // ********************

   assign sample_valid             = fifo_out_valid;
   assign sample_out               = fifo_out_data;
   assign start_trigger_output_pin = st.start_pulse;
   assign start_trigger_pin_oe     = st.oe;
   assign acq_running              = st.running;
   assign acq_complete             = st.complete;
   assign acq_overflow             = st.overflow;
   assign sample_tick              = st.tick;
   assign sample_count             = st.count;
endmodule // atseq_sequencer

// ---- atseq_pkg.sv ----
/*
 Constants and types of the acquisition trigger sequencer.
 Assumes one 125 MHz clock and a synchronous active-high reset.
*/
// Notes on behaviour
// - Posttrigger-only run loads post count, counts ticks down, ends at zero.
// - Pretrigger run loads pre count on start trigger, counts ticks down.
// - Pretrigger count at zero reloads counter with post count.
// - Reference trigger before pretrigger samples are taken is ignored.
// - After accepted reference trigger, count post samples then stop.
// - Start is hardware or software; software start pulses start output.
// - Stops: finite count, finite reference trigger, continuous software stop.
// - Digital start source: any function pin, timing bus 0..6, internal.
// - Digital start acts on selectable rising or falling edge.
// - Analog source starts on first rising edge of comparison event.
// - Start pin as output mirrors internal start trigger, any source.
// - Routed trigger output is an active-high pulse.
// - After reset the start trigger pin is an input.
// - Start trigger starts tick counter; first tick delay default two timebase ticks.
// - Post count equals buffer size minus pretrigger count.
package atseq_pkg;
   // ********************
   // Sizes
   // ********************
   localparam int COUNT_W   = 24;
   localparam int PIN_N     = 10;
   localparam int BUS_N     = 7;
   localparam int INT_N     = 4;
   localparam int SEL_W     = 5;
   localparam int DIV_W     = 16;
   localparam int DELAY_W   = 8;
   localparam logic [DELAY_W-1:0] FIRST_DELAY_DEFAULT = 8'h02;
   localparam logic [DIV_W-1:0]   DIV_DEFAULT         = 16'h0004;
   localparam logic [COUNT_W-1:0] COUNT_ZERO          = 24'h00_0000;
   localparam logic [COUNT_W-1:0] COUNT_ONE           = 24'h00_0001;

   // ********************
   // Types
   // ********************
   typedef enum logic [1:0] {
      ATSEQ_SRC_SOFT,
      ATSEQ_SRC_DIGITAL,
      ATSEQ_SRC_ANALOG,
      ATSEQ_SRC_NONE
   } atseq_src_t;

   typedef enum logic [1:0] {
      ATSEQ_STOP_COUNT,
      ATSEQ_STOP_REF,
      ATSEQ_STOP_CONT
   } atseq_stop_t;

   typedef enum logic [2:0] {
      ATSEQ_IDLE,
      ATSEQ_DELAY,
      ATSEQ_PRE,
      ATSEQ_ARMED,
      ATSEQ_POST,
      ATSEQ_RUN
   } atseq_state_t;
endpackage

// ---- atseq_fifo.sv ----
/*
 Sample FIFO with valid/ready on both sides.
 Assumes one clock, synchronous active-high reset.
*/
module atseq_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   initial
   begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
   end

   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0]   level;
      logic          nonempty;
   } atseq_fifo_t;

   atseq_fifo_t           st;
   atseq_fifo_t           next_st;
   logic [WIDTH-1:0]      mem [DEPTH];
   logic                  push;
   logic                  pop;

   assign in_ready  = st.level != (AW+1)'(DEPTH);
   assign out_valid = st.nonempty;
   assign out_data  = mem[st.rd];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb
   begin
      next_st = st;
      if (push) next_st.wr = st.wr + 1'b1;
      if (pop) next_st.rd = st.rd + 1'b1;
      next_st.level = st.level + (AW+1)'(push) - (AW+1)'(pop);
      next_st.nonempty = next_st.level != '0;
   end

   always_ff @(posedge clk)
   begin
      if (reset) st <= '0;
      else st <= next_st;
      if (push) mem[st.wr] <= in_data;
   end
endmodule // atseq_fifo

// ---- atseq_properties.sv ----
/*
 Port checker of the acquisition trigger sequencer.
 Assumes a bind onto atseq_sequencer, one clock, sync reset.
*/
module atseq_checker (
   // Clock and reset
   input wire logic                          clk,
   input wire logic                          reset,
   // Host side
   input wire atseq_pkg::atseq_src_t         start_src,
   input wire atseq_pkg::atseq_stop_t        stop_mode,
   input wire logic [atseq_pkg::COUNT_W-1:0] buffer_size,
   input wire logic [atseq_pkg::COUNT_W-1:0] pretrigger_count,
   input wire logic                          start_pin_output,
   input wire logic                          sw_start,
   input wire logic                          sw_stop,
   // Outputs
   input wire logic                          start_trigger_output_pin,
   input wire logic                          start_trigger_pin_oe,
   input wire logic                          acq_running,
   input wire logic                          acq_complete,
   input wire logic                          sample_tick,
   input wire logic [atseq_pkg::COUNT_W-1:0] sample_count
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   // ****************
   // Assertions
   // ****************
   a_soft_start: assert property (
      sw_start && !acq_running && start_src == atseq_pkg::ATSEQ_SRC_SOFT
      |=> acq_running && start_trigger_output_pin == start_trigger_pin_oe)
      else $error("software start not taken");
   a_out_at_start: assert property (
      start_trigger_output_pin |-> $rose(acq_running) && start_trigger_pin_oe)
      else $error("start output pulse outside start");
   a_out_pulse: assert property (
      start_trigger_output_pin |=> !start_trigger_output_pin)
      else $error("start output pulse too long");
   a_oe_follow: assert property (start_pin_output |=> start_trigger_pin_oe)
      else $error("start pin not output");
   a_oe_input: assert property (!start_pin_output |=> !start_trigger_pin_oe)
      else $error("start pin not input");
   a_tick_pulse: assert property (sample_tick |=> !sample_tick)
      else $error("sample tick too long");
   a_count_hold: assert property (
      !acq_running && $past(acq_running) == 1'b0 |-> $stable(sample_count))
      else $error("sample count moved while idle");
   a_post_load: assert property (
      $rose(acq_running) && stop_mode == atseq_pkg::ATSEQ_STOP_COUNT
      |-> sample_count == buffer_size - pretrigger_count)
      else $error("post count not loaded");
   a_done_zero: assert property (
      $rose(acq_complete) |-> !acq_running && sample_count == atseq_pkg::COUNT_ZERO)
      else $error("complete without zero count");
   a_stop_idle: assert property (sw_stop && acq_running |=> !acq_running && !acq_complete)
      else $error("software stop not taken");

   c_start: cover property ($rose(acq_running));
   c_done: cover property ($rose(acq_complete));
   c_stop: cover property (sw_stop && acq_running);
endmodule // atseq_checker

// ---- atseq_source_model.sv ----
/*
 Far-side model: trigger sources, free timebase and sample data.
 Assumes bench control inputs change at rising clock edges.
*/
module atseq_source_model (
   // Clock
   input wire logic    clk,
   // Bench control
   input wire logic [4:0] trig_idx,
   input wire logic    trig_lvl,
   input wire logic    trig_pol,
   // Start pin driver
   input wire logic    pin_drive,
   input wire logic    pin_oe,
   // Source lines
   output logic [9:0]  function_pin,
   output logic [6:0]  bus_line,
   output logic [3:0]  internal_line,
   output logic        analog_event,
   output logic        pin_level,
   output logic        timebase,
   output logic [15:0] sample_data
);
   logic [21:0] v;
   logic [2:0]  ph = 3'h0;
   logic [15:0] cnt = 16'h0000;
   // Selected line leaves its idle level
   assign v = {22{trig_pol}} ^ (trig_lvl ? 22'h00_0001 << trig_idx : 22'h00_0000);
   // Pin wire level from both drivers
   assign pin_level = pin_oe ? pin_drive : v[0];
   assign function_pin = {v[9:1], pin_level};
   assign bus_line = v[16:10];
   assign internal_line = v[20:17];
   assign analog_event = v[21];
   assign timebase = ph[2];
   assign sample_data = cnt;
   always @(posedge clk)
   begin
      ph <= ph + 3'h1;
      cnt <= cnt + 16'h0001;
   end
endmodule // atseq_source_model

// ---- tb_acquisition_trigger_sequencer.sv ----
/*
 Self-checking bench of the acquisition trigger sequencer.
 Assumes package, design, checker and source model compile first.
*/
module tb_acquisition_trigger_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      atseq_pkg::atseq_src_t src;
      logic [4:0]            sel;
      logic                  fall;
      logic [23:0]           size;
      int                    ticks;
   } atseq_row_t;
   logic clk = 1'b0, reset = 1'b1, start_falling = 1'b0, start_pin_output = 1'b0;
   logic sw_start = 1'b0, sw_stop = 1'b0, trig_lvl = 1'b0, trig_pol = 1'b0, sample_ready = 1'b1;
   atseq_pkg::atseq_src_t start_src = atseq_pkg::ATSEQ_SRC_SOFT;
   atseq_pkg::atseq_src_t ref_src = atseq_pkg::ATSEQ_SRC_NONE;
   atseq_pkg::atseq_stop_t stop_mode = atseq_pkg::ATSEQ_STOP_COUNT;
   logic [4:0] start_sel = 5'h00, ref_sel = 5'h05, trig_idx = 5'h00;
   logic [23:0] buffer_size = 24'h00_0001, pretrigger_count = 24'h00_0000, sample_count;
   logic [9:0] programmable_function_pin;
   logic [6:0] system_timing_bus_line;
   logic [3:0] internal_source;
   logic [15:0] sample_data, sample_out;
   logic analog_compare_event, sample_tick_timebase, start_trigger_pin_in, sample_tick;
   logic start_trigger_output_pin, start_trigger_pin_oe, sample_valid;
   logic acq_running, acq_complete, acq_overflow;
   int nt = 0, np = 0, nw = 0, cyc = 0, t0, p0, err_count = 0, total_checks = 0;
   atseq_row_t rows [6] = '{
      '{atseq_pkg::ATSEQ_SRC_SOFT, 5'h00, 1'b0, 24'h00_0005, 5},
      '{atseq_pkg::ATSEQ_SRC_NONE, 5'h00, 1'b0, 24'h00_0001, 1},
      '{atseq_pkg::ATSEQ_SRC_DIGITAL, 5'h03, 1'b0, 24'h00_0003, 3},
      '{atseq_pkg::ATSEQ_SRC_DIGITAL, 5'h12, 1'b0, 24'h00_0002, 2},
      '{atseq_pkg::ATSEQ_SRC_DIGITAL, 5'h0C, 1'b1, 24'h00_0002, 2},
      '{atseq_pkg::ATSEQ_SRC_ANALOG, 5'h15, 1'b0, 24'h00_0002, 2}};

   atseq_sequencer i_dut (.*, .ref_falling(1'b0), .tick_falling(1'b0),
      .tick_divisor(16'h0001), .first_tick_delay(atseq_pkg::FIRST_DELAY_DEFAULT));
   atseq_source_model i_src (.clk(clk), .trig_idx(trig_idx), .trig_lvl(trig_lvl),
      .trig_pol(trig_pol), .pin_drive(start_trigger_output_pin),
      .pin_oe(start_trigger_pin_oe), .function_pin(programmable_function_pin),
      .bus_line(system_timing_bus_line), .internal_line(internal_source),
      .analog_event(analog_compare_event), .pin_level(start_trigger_pin_in),
      .timebase(sample_tick_timebase), .sample_data(sample_data));

   // ****************
   // Clock and monitors
   // ****************
   initial
   begin
      forever #4 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (sample_tick === 1'b1)
         nt <= nt + 1;
      if (start_trigger_output_pin === 1'b1)
         np <= np + 1;
      if (sample_valid === 1'b1 && sample_ready === 1'b1)
         nw <= nw + 1;
      if (cyc == 20000)
      begin
         err_count++;
         print_verdict();
      end
   end

   // ****************
   // Tasks
   // ****************
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic pulse(input logic stop, input int n);
      @(posedge clk);
      if (stop)
         sw_stop <= 1'b1;
      else if (n == 0)
         sw_start <= 1'b1;
      else
         trig_lvl <= 1'b1;
      repeat (n + 1) @(posedge clk);
      sw_stop <= 1'b0;
      sw_start <= 1'b0;
      trig_lvl <= 1'b0;
   endtask
   task automatic begin_run(input atseq_row_t r);
      @(posedge clk);
      start_src <= r.src;
      start_sel <= r.sel;
      start_falling <= r.fall;
      trig_idx <= r.sel;
      buffer_size <= r.size;
      repeat (3) @(posedge clk);
      trig_pol <= r.fall;
      repeat (8) @(posedge clk);
      t0 = nt;
      p0 = np;
      pulse(1'b0, (r.src == atseq_pkg::ATSEQ_SRC_DIGITAL || r.src == atseq_pkg::ATSEQ_SRC_ANALOG) ? 5 : 0);
   endtask
   task automatic wait_done;
      int n;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (acq_complete !== 1'b1 && n < 4000);
      repeat (2) @(negedge clk);
   endtask
   task automatic wait_ticks(input int k);
      int s;
      int n;
      s = nt;
      n = 0;
      while (nt - s < k && n < 4000)
      begin
         @(negedge clk);
         n++;
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ****************
   // Main sequence
   // ****************
   initial
   begin
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk);
      chk({start_trigger_pin_oe, acq_running, acq_complete, sample_valid}, 0);
      $display("reset test done");
      @(posedge clk);
      start_pin_output <= 1'b1;
      foreach (rows[i])
      begin
         begin_run(rows[i]);
         wait_done();
         chk(nt - t0, rows[i].ticks);
         chk(np - p0, 1);
         chk(acq_complete, 1);
         $display("row %0d done", i);
      end
      $display("row tests done");
      stop_mode <= atseq_pkg::ATSEQ_STOP_REF;
      ref_src <= atseq_pkg::ATSEQ_SRC_DIGITAL;
      pretrigger_count <= 24'h00_0004;
      begin_run('{atseq_pkg::ATSEQ_SRC_SOFT, 5'h05, 1'b0, 24'h00_0007, 0});
      pulse(1'b0, 3);
      wait_ticks(5);
      chk(acq_complete, 0);
      chk(sample_count, 3);
      t0 = nt;
      pulse(1'b0, 3);
      wait_done();
      chk(nt - t0, 3);
      chk(acq_complete, 1);
      $display("reference test done");
      stop_mode <= atseq_pkg::ATSEQ_STOP_CONT;
      begin_run(rows[0]);
      wait_ticks(10);
      chk(acq_running, 1);
      p0 = np;
      pulse(1'b0, 0);
      pulse(1'b1, 0);
      @(negedge clk);
      chk(np - p0, 0);
      chk({acq_running, acq_complete}, 0);
      t0 = sample_count;
      repeat (30) @(negedge clk);
      chk(sample_count, t0);
      $display("continuous test done");
      stop_mode <= atseq_pkg::ATSEQ_STOP_COUNT;
      pretrigger_count <= 24'h00_0000;
      sample_ready <= 1'b0;
      begin_run('{atseq_pkg::ATSEQ_SRC_SOFT, 5'h00, 1'b0, 24'h00_0014, 0});
      t0 = nw;
      wait_done();
      chk({acq_overflow, sample_valid}, 3);
      p0 = sample_out;
      @(posedge clk);
      sample_ready <= 1'b1;
      repeat (2) @(negedge clk);
      chk(sample_out - p0[15:0], 24'h00_0008);
      repeat (38) @(negedge clk);
      chk(nw - t0, 16);
      chk(sample_valid, 0);
      $display("buffer test done");
      print_verdict();
   end
endmodule // tb_acquisition_trigger_sequencer

bind atseq_sequencer atseq_checker i_chk (
   .clk                      (clk),
   .reset                    (reset),
   .start_src                (start_src),
   .stop_mode                (stop_mode),
   .buffer_size              (buffer_size),
   .pretrigger_count         (pretrigger_count),
   .start_pin_output         (start_pin_output),
   .sw_start                 (sw_start),
   .sw_stop                  (sw_stop),
   .start_trigger_output_pin (start_trigger_output_pin),
   .start_trigger_pin_oe     (start_trigger_pin_oe),
   .acq_running              (acq_running),
   .acq_complete             (acq_complete),
   .sample_tick              (sample_tick),
   .sample_count             (sample_count)
);
